// ---- rtl/pbc_pkg.sv ----
// shared constants for the polling bit-check sequencer
package pbc_pkg;
    localparam int          PBC_DIV_A        = 28;     // base tick divider, variant a
    localparam int          PBC_DIV_B        = 30;     // base tick divider, variant b
    localparam int          PBC_SLEEP_UNIT   = 1024;   // base ticks per sleep unit
    localparam int          PBC_XSLEEP_ON    = 8;      // extension factor when set
    localparam int          PBC_XSLEEP_OFF   = 1;      // extension factor when clear
    localparam logic [4:0]  PBC_SLEEP_MAX    = 5'h1f;  // permanent sleep code
    localparam logic [4:0]  PBC_LIM_MIN_RST  = 5'h0e;  // reset lower limit
    localparam logic [5:0]  PBC_LIM_MAX_RST  = 6'h18;  // reset upper limit
    localparam logic [1:0]  PBC_BR_RST       = 2'h0;   // reset baud range
    localparam logic [1:0]  PBC_NBIT_RST     = 2'h1;   // reset bit-check count code
    localparam logic [4:0]  PBC_SLEEP_RST    = 5'h05;  // reset sleep setting
    localparam int          PBC_STARTUP_TICKS = 64;    // start-up settle, base ticks
    localparam int          PBC_CNT_W        = 6;      // bit-check counter width

    typedef enum logic [2:0] {
        PBC_SLEEP,
        PBC_STARTUP,
        PBC_CHECK,
        PBC_RECEIVE
    } pbc_state_type;
endpackage

// ---- rtl/pbc_tick_if.sv ----
// tick signals passed from the divider to the sequencer
`timescale 1ns/1ps
interface pbc_tick_if;
    logic base_tick;   // one pulse per base tick
    logic ext_tick;    // one pulse per extended tick
    modport src (output base_tick, output ext_tick);
    modport dst (input base_tick, input ext_tick);
endinterface

// ---- rtl/pbc_tick_gen.sv ----
// base and extended tick divider
`timescale 1ns/1ps
module pbc_tick_gen
    import pbc_pkg::*;
(
    input  wire logic       clk_sys,       // crystal-derived clock
    input  wire logic       rst_n,         // async reset, active low
    input  wire logic       div_sel,       // 0: divide 28, 1: divide 30
    input  wire logic [1:0] baud_range_select, // extended tick scale
    pbc_tick_if.src         tk             // tick outputs
);
    logic [4:0] div_cnt;
    logic [2:0] ext_cnt;
    wire  [4:0] div_last = div_sel ? 5'(PBC_DIV_B - 1) : 5'(PBC_DIV_A - 1);
    wire        wrap     = (div_cnt == div_last);
    // 8, 4, 2 or 1 base ticks per extended tick
    wire  [2:0] ext_last = 3'h7 >> baud_range_select;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            div_cnt <= 5'h00;
        end else begin
            div_cnt <= wrap ? 5'h00 : div_cnt + 5'h01;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ext_cnt <= 3'h0;
        end else if (wrap) begin
            ext_cnt <= (ext_cnt >= ext_last) ? 3'h0 : ext_cnt + 3'h1;
        end
    end

    assign tk.base_tick = wrap;
    assign tk.ext_tick  = wrap && (ext_cnt >= ext_last);
endmodule

// ---- rtl/pbc_seq.sv ----
// polling sequencer: sleep, start-up, bit check, receive
`timescale 1ns/1ps
// How it works
// - base tick is crystal divided by 28/30
// - extended tick is 8,4,2,1 base ticks
// - polling loops sleep, start-up, bit check
// - start-up enables processing and lets it settle
// - no edge evaluation during start-up
// - failed check returns to sleep
// - activity output marks non-sleep states
// - sleep lasts setting times factor times 1024
// - extension factor 8 when bit set
// - maximum sleep setting sleeps forever
// - count code gives 0,6,12,18 passing edges
// - counter counts extended ticks between edges
// - window is min to max minus one
// - edge below minimum fails the check
// - counter reaching maximum fails at once
// - data routed to output after success
// - receive mode held until polling command
// - polling pin low forces wake, keeps settings
module pbc_seq
    import pbc_pkg::*;
#(
    parameter int STARTUP_TICKS = PBC_STARTUP_TICKS  // settle length in base ticks
)(
    input  wire logic       clk_sys,            // 250 MHz system clock
    input  wire logic       rst_n,              // async reset, active low
    input  wire logic       div_sel,            // divider variant: 0 = 28, 1 = 30
    input  wire logic [1:0] baud_range_select,  // extended tick scale
    input  wire logic [4:0] sleep_setting,      // 5-bit sleep word
    input  wire logic       sleep_extend_bit,   // sleep factor 8 when high
    input  wire logic [1:0] bit_check_count,    // 0,3,6,9 bits
    input  wire logic [4:0] lim_min,            // lower window limit
    input  wire logic [5:0] lim_max,            // upper window limit
    input  wire logic       polling_on_n,       // low: force wake-up
    input  wire logic       back_to_polling,    // pulse: leave receive mode
    input  wire logic       dem_data,           // demodulated data, synchronous
    output logic            activity_indicator, // high when awake
    output logic            proc_enable,        // signal processing enable
    output logic            data_out,           // routed data in receive mode
    output logic            data_valid,         // data_out is carrying data
    output logic [5:0]      edge_interval_count // bit-check counter value
);
    pbc_tick_if tk ();

    pbc_tick_gen u_tick (
        .clk_sys           (clk_sys),
        .rst_n             (rst_n),
        .div_sel           (div_sel),
        .baud_range_select (baud_range_select),
        .tk                (tk)
    );

    // ----------------------------------------------------------------
    // state and timers
    // ----------------------------------------------------------------
    pbc_state_type state;
    pbc_state_type next_state;
    logic [17:0]   sleep_cnt;
    logic [17:0]   startup_cnt;
    logic [4:0]    pass_cnt;
    logic          dem_q;

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    // sleep length in base ticks; up to 31*8*1024 fits 18 bits
    wire [17:0] sleep_len = {3'h0, sleep_setting, 10'h000}
                            << (sleep_extend_bit ? 2'h3 : 2'h0);
    wire        sleep_forever = (sleep_setting == PBC_SLEEP_MAX);
    wire        force_wake    = !polling_on_n;
    wire        sleep_done    = tk.base_tick && (sleep_cnt + 18'h1 >= sleep_len);
    wire        wake          = force_wake || (!sleep_forever && sleep_done);
    wire        startup_done  = tk.base_tick
                                && (startup_cnt == 18'(STARTUP_TICKS - 1));
    // count code n -> 6n passing edges
    // widen both terms first: 6*3 = 18 overflows a 4-bit sum
    wire [4:0]  pass_need     = {1'h0, bit_check_count, 2'h0}
                                + {2'h0, bit_check_count, 1'h0};
    wire        edge_seen     = (dem_data != dem_q);
    wire        in_check      = (state == PBC_CHECK);
    wire        too_short     = edge_seen && (edge_interval_count < {1'h0, lim_min});
    // counter reaching max fails immediately; upper bound is max-1
    wire        too_long      = (edge_interval_count >= lim_max);
    wire        edge_ok       = in_check && edge_seen && !too_short && !too_long;
    wire        check_fail    = in_check && (too_short || too_long);
    wire        check_pass    = edge_ok && (pass_cnt + 5'h01 >= pass_need);

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb begin
        next_state = state;
        unique case (state)
            PBC_SLEEP:   if (wake) next_state = PBC_STARTUP;
            PBC_STARTUP: begin
                if (startup_done) begin
                    // zero count skips the edge tests
                    next_state = (pass_need == 5'h00) ? PBC_RECEIVE
                                                      : PBC_CHECK;
                end
            end
            PBC_CHECK: begin
                if (check_fail)      next_state = PBC_SLEEP;
                else if (check_pass) next_state = PBC_RECEIVE;
            end
            PBC_RECEIVE: if (back_to_polling) next_state = PBC_SLEEP;
            default:     next_state = PBC_SLEEP;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) state <= PBC_SLEEP;
        else        state <= next_state;
    end

    // ----------------------------------------------------------------
    // timers
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sleep_cnt <= 18'h0;
        end else if (state != PBC_SLEEP) begin
            sleep_cnt <= 18'h0;
        end else if (tk.base_tick && !sleep_done) begin
            sleep_cnt <= sleep_cnt + 18'h1;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            startup_cnt <= 18'h0;
        end else if (state != PBC_STARTUP) begin
            startup_cnt <= 18'h0;
        end else if (tk.base_tick) begin
            startup_cnt <= startup_cnt + 18'h1;
        end
    end

    // ----------------------------------------------------------------
    // bit-check counter and pass count
    // ----------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            dem_q <= 1'b0;
        end else begin
            dem_q <= dem_data;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            edge_interval_count <= 6'h00;
        end else if (!in_check || edge_ok) begin
            edge_interval_count <= 6'h00;
        end else if (tk.ext_tick && edge_interval_count != 6'h3f) begin
            edge_interval_count <= edge_interval_count + 6'h01;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n)        pass_cnt <= 5'h00;
        else if (!in_check) pass_cnt <= 5'h00;
        else if (edge_ok)   pass_cnt <= pass_cnt + 5'h01;
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    // data hidden until receive mode so noise never reaches the host
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            activity_indicator <= 1'b0;
            proc_enable        <= 1'b0;
            data_out           <= 1'b1;
            data_valid         <= 1'b0;
        end else begin
            activity_indicator <= (next_state != PBC_SLEEP);
            proc_enable        <= (next_state != PBC_SLEEP);
            data_valid         <= (next_state == PBC_RECEIVE);
            data_out           <= (next_state == PBC_RECEIVE) ? dem_data : 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    tick_period_a: assert property (tk.base_tick |=> !tk.base_tick [*8])
        else $error("base tick too frequent");
    ext_subset_a: assert property (tk.ext_tick |-> tk.base_tick)
        else $error("extended tick off base tick");
    sleep_loop_a: assert property (state == PBC_SLEEP && next_state != PBC_SLEEP
                                   |-> next_state == PBC_STARTUP)
        else $error("sleep left to wrong state");
    no_startup_check_a: assert property (state == PBC_STARTUP |-> !check_fail)
        else $error("edge evaluated in start-up");
    fail_sleep_a: assert property (check_fail |=> state == PBC_SLEEP)
        else $error("failed check did not sleep");
    active_ind_a: assert property ((state != PBC_SLEEP) |-> activity_indicator)
        else $error("indicator low while awake");
    perm_sleep_a: assert property (state == PBC_SLEEP && sleep_forever && polling_on_n
                                   |=> state == PBC_SLEEP)
        else $error("woke from permanent sleep");
    short_fail_a: assert property (in_check && edge_seen
                                   && edge_interval_count < {1'h0, lim_min}
                                   |=> state == PBC_SLEEP)
        else $error("short interval accepted");
    max_fail_a: assert property (in_check && edge_interval_count >= lim_max
                                 |=> state == PBC_SLEEP)
        else $error("max reached without fail");
    force_wake_a: assert property (state == PBC_SLEEP && !polling_on_n
                                   |=> state == PBC_STARTUP)
        else $error("forced wake ignored");
    route_data_a: assert property (state == PBC_RECEIVE && $past(state) == PBC_RECEIVE
                                   |-> data_out == $past(dem_data))
        else $error("data not routed");
    hold_rx_a: assert property (state == PBC_RECEIVE && !back_to_polling
                                |=> state == PBC_RECEIVE)
        else $error("receive mode left");

    pass_c:    cover property (state == PBC_CHECK ##1 state == PBC_RECEIVE);
    fail_c:    cover property (state == PBC_CHECK ##1 state == PBC_SLEEP);
    direct_c:  cover property (state == PBC_STARTUP ##1 state == PBC_RECEIVE);
endmodule

// ---- bench/pbc_dem_model.sv ----
// demodulator stand-in: square wave on the data line at a chosen edge spacing
`timescale 1ns/1ps
module pbc_dem_model (
    input  wire logic clk_sys,     // system clock
    input  wire logic rst_n,       // async reset, active low
    input  wire logic signed [31:0] half_period, // clocks between edges, 0 holds the line
    output logic      dem_data     // demodulated data
);
    int cnt;
    // spacing restarts from zero only after the period has been held at 0
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cnt      <= 0;
            dem_data <= 1'b1;
        end else if (half_period == 0) begin
            cnt <= 0;
        end else if (cnt >= half_period - 1) begin
            cnt      <= 0;
            dem_data <= ~dem_data;
        end else begin
            cnt <= cnt + 1;
        end
    end
endmodule

// ---- bench/polling_bit_check_sequencer_test.sv ----
// self-checking bench for the polling bit-check sequencer
`timescale 1ns/1ps
module polling_bit_check_sequencer_test;
    import pbc_pkg::*;
    logic       clk_sys           = 1'b0;
    logic       rst_n             = 1'b0;
    logic       div_sel           = 1'b0;
    logic [1:0] baud_range_select = 2'h3;
    logic [4:0] sleep_setting     = 5'h1f;
    logic       sleep_extend_bit  = 1'b0;
    logic [1:0] bit_check_count   = 2'h2;
    logic [4:0] lim_min           = 5'h0a;
    logic [5:0] lim_max           = 6'h0e;
    logic       polling_on_n      = 1'b1;
    logic       back_to_polling   = 1'b0;
    logic       dem_data, activity_indicator, proc_enable, data_out, data_valid;
    logic [5:0] edge_interval_count;
    int         half_period = 0;
    int         fails = 0;
    int         comparisons = 0;

    always #2 clk_sys = ~clk_sys;

    pbc_seq #(.STARTUP_TICKS(2)) uut (
        .clk_sys(clk_sys), .rst_n(rst_n), .div_sel(div_sel),
        .baud_range_select(baud_range_select), .sleep_setting(sleep_setting),
        .sleep_extend_bit(sleep_extend_bit), .bit_check_count(bit_check_count),
        .lim_min(lim_min), .lim_max(lim_max), .polling_on_n(polling_on_n),
        .back_to_polling(back_to_polling), .dem_data(dem_data),
        .activity_indicator(activity_indicator), .proc_enable(proc_enable),
        .data_out(data_out), .data_valid(data_valid),
        .edge_interval_count(edge_interval_count));

    pbc_dem_model dem (.clk_sys(clk_sys), .rst_n(rst_n), .half_period(half_period),
        .dem_data(dem_data));

    task automatic report_and_stop;
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        comparisons++;
        if (seen !== want) begin
            fails++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, want);
        end
    endtask

    // sampling on the falling edge keeps clear of the design's own updates
    task automatic wait_act(input logic lvl, input int bound, output int n);
        n = 0;
        while (activity_indicator !== lvl && n < bound) begin
            @(negedge clk_sys);
            n++;
        end
        if (n >= bound) begin
            fails++;
            report_and_stop();
        end
    endtask

    task automatic wait_cnt(input logic [5:0] v, input int bound, output int n);
        n = 0;
        while (edge_interval_count !== v && n < bound) begin
            @(negedge clk_sys);
            n++;
        end
        if (n >= bound) begin
            fails++;
            report_and_stop();
        end
    endtask

    // counter step is the extended tick; a short edge then ends the check
    task automatic t_tick(input logic d, input logic [1:0] br);
        int n;
        @(posedge clk_sys);
        div_sel <= d;
        baud_range_select <= br;
        polling_on_n <= 1'b0;
        wait_cnt(6'h01, 5000, n);
        wait_cnt(6'h02, 300, n);
        check(n, (d ? PBC_DIV_B : PBC_DIV_A) * (8 >> br));
        @(posedge clk_sys);
        polling_on_n <= 1'b1;
        half_period <= 2;
        wait_act(1'b0, 50, n);
        check(proc_enable, 1'b0);
        @(posedge clk_sys);
        half_period <= 0;
    endtask

    task automatic t_pass;
        int   n;
        int   edges;
        logic d;
        edges = 0;
        @(posedge clk_sys);
        div_sel <= 1'b0;
        polling_on_n <= 1'b0;
        wait_cnt(6'h01, 5000, n);
        @(posedge clk_sys);
        half_period <= 11 * PBC_DIV_A;
        polling_on_n <= 1'b1;
        d = dem_data;
        for (n = 0; n < 6000 && data_valid !== 1'b1; n++) begin
            @(negedge clk_sys);
            edges += (dem_data !== d);
            d = dem_data;
        end
        check(edges, 12);
        repeat (700) begin
            d = dem_data;
            @(negedge clk_sys);
            check(data_out, d);
        end
        check({activity_indicator, data_valid}, 2'h3);
        @(posedge clk_sys);
        back_to_polling <= 1'b1;
        half_period <= 0;
        @(posedge clk_sys);
        back_to_polling <= 1'b0;
        wait_act(1'b0, 20, n);
        check(data_valid, 1'b0);
    endtask

    task automatic t_zero;
        int n;
        @(posedge clk_sys);
        bit_check_count <= 2'h0;
        polling_on_n <= 1'b0;
        for (n = 0; n < 500 && data_valid !== 1'b1; n++) begin
            @(negedge clk_sys);
        end
        check({data_valid, activity_indicator, proc_enable}, 3'h7);
        @(posedge clk_sys);
        polling_on_n <= 1'b1;
        back_to_polling <= 1'b1;
        @(posedge clk_sys);
        back_to_polling <= 1'b0;
        bit_check_count <= 2'h2;
        wait_act(1'b0, 20, n);
    endtask

    // no edges: the counter hits the upper limit, then a full sleep period
    task automatic t_sleep;
        int n;
        @(posedge clk_sys);
        sleep_setting <= 5'h01;
        polling_on_n <= 1'b0;
        wait_cnt(6'h01, 5000, n);
        @(posedge clk_sys);
        polling_on_n <= 1'b1;
        wait_act(1'b0, 1000, n);
        check(n >= 13 * PBC_DIV_A && n <= 13 * PBC_DIV_A + 2, 1'b1);
        wait_act(1'b1, 40000, n);
        check(n >= PBC_SLEEP_UNIT * PBC_DIV_A - 56 && n <= PBC_SLEEP_UNIT * PBC_DIV_A + 56,
              1'b1);
        wait_cnt(6'h01, 5000, n);
        @(posedge clk_sys);
        sleep_extend_bit <= 1'b1;
        wait_act(1'b0, 1000, n);
        repeat (30000) @(negedge clk_sys);
        check(activity_indicator, 1'b0);
        @(posedge clk_sys);
        sleep_setting <= PBC_SLEEP_MAX;
        repeat (3000) @(negedge clk_sys);
        check(activity_indicator, 1'b0);
    endtask

    initial begin
        repeat (10) @(posedge clk_sys);
        check({activity_indicator, proc_enable, data_out, data_valid}, 4'h2);
        check(edge_interval_count, 6'h00);
        rst_n <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            t_tick(i[2], i[1:0]);
        end
        t_pass();
        t_zero();
        t_sleep();
        report_and_stop();
    end
endmodule
